// [pcm_pkg.sv]
// Purpose: shared constants and types of the voice sample serial port
// Assumes: core clock of 100 MHz
// Notes: phase steps drive a 32-bit accumulator whose top bit is the bit clock
package pcm_pkg;

    localparam longint CORE_CLK_HZ = 100_000_000;
    localparam int SAMPLE_BITS = 16;
    localparam int SYNC_STAGES = 2;

    // bit clock rate choices
    typedef enum logic [2:0] {
        RATE_256,
        RATE_512,
        RATE_1024,
        RATE_2048,
        RATE_4096
    } bclk_rate_t;

    localparam longint KHZ = 1000;
    localparam longint FS_BASE_KHZ = 8;
    localparam longint FS_FAST_KHZ = 16;
    localparam longint BCLK_256_KHZ = 256;
    localparam longint BCLK_512_KHZ = 512;
    localparam longint BCLK_1024_KHZ = 1024;
    localparam longint BCLK_2048_KHZ = 2048;
    localparam longint BCLK_4096_KHZ = 4096;
    localparam longint PHASE_ONE = 64'h1_0000_0000;

    localparam logic [31:0] STEP_256 = 32'(BCLK_256_KHZ * KHZ * PHASE_ONE / CORE_CLK_HZ);
    localparam logic [31:0] STEP_512 = 32'(BCLK_512_KHZ * KHZ * PHASE_ONE / CORE_CLK_HZ);
    localparam logic [31:0] STEP_1024 = 32'(BCLK_1024_KHZ * KHZ * PHASE_ONE / CORE_CLK_HZ);
    localparam logic [31:0] STEP_2048 = 32'(BCLK_2048_KHZ * KHZ * PHASE_ONE / CORE_CLK_HZ);
    localparam logic [31:0] STEP_4096 = 32'(BCLK_4096_KHZ * KHZ * PHASE_ONE / CORE_CLK_HZ);

    localparam logic [8:0] FRAME_256 = 9'(BCLK_256_KHZ / FS_BASE_KHZ);
    localparam logic [8:0] FRAME_512 = 9'(BCLK_512_KHZ / FS_BASE_KHZ);
    localparam logic [8:0] FRAME_1024 = 9'(BCLK_1024_KHZ / FS_BASE_KHZ);
    localparam logic [8:0] FRAME_2048 = 9'(BCLK_2048_KHZ / FS_BASE_KHZ);
    localparam logic [8:0] FRAME_4096 = 9'(BCLK_4096_KHZ / FS_FAST_KHZ);
    localparam logic [8:0] BIT_IDLE = 9'h1ff;
    localparam logic [8:0] LAST_DATA_BIT = 9'(SAMPLE_BITS - 1);

    // start-up configuration
    localparam bclk_rate_t DEFAULT_RATE = RATE_2048;
    localparam logic DEFAULT_LONG = 1'b0;
    localparam logic DEFAULT_MASTER = 1'b1;

    // two-wire control link
    localparam longint CTL_KHZ = 100;
    localparam logic [7:0] CTL_QUARTER = 8'(CORE_CLK_HZ / (4 * CTL_KHZ * KHZ) - 1);
    localparam logic [1:0] CTL_LAST_BYTE = 2'h2;

endpackage : pcm_pkg

// [bit_sync.sv]
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to core_clk
// Notes: only the second stage may be read by other logic
`timescale 1ns/1ns
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import pcm_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    // first stage feeds only the second
    always_comb begin
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;

endmodule : bit_sync

// [ctl_link_master.sv]
// Purpose: two-wire control link master writing one register of the codec
// Assumes: sda_in already synchronised; both lines pulled up outside
// Notes: a write is address, register, data; a missing acknowledge ends it early
`timescale 1ns/1ns
module ctl_link_master (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_reg,
    input wire logic [7:0] cmd_data,
    output logic busy,
    output logic nack,
    input wire logic sda_in,
    output logic scl_o,
    output logic scl_oe_n,
    output logic sda_o,
    output logic sda_oe_n
);
    import pcm_pkg::*;

    typedef enum logic [2:0] {IDLE, START, SEND, ACK, STOP} ctl_fsm_t;

    typedef struct packed {
        ctl_fsm_t fsm;
        logic [7:0] tick;
        logic [1:0] quarter;
        logic [1:0] byte_idx;
        logic [2:0] bit_idx;
        logic [7:0] shift;
        logic [15:0] rest;
        logic scl_low;
        logic sda_low;
        logic nack;
    } ctl_state_t;

    ctl_state_t st_q;
    ctl_state_t st_d;
    logic q_end;

    // each bit is four quarter periods; the clock is always ours
    always_comb begin
        st_d = st_q;
        q_end = (st_q.tick == CTL_QUARTER);
        if (st_q.fsm != IDLE) begin
            st_d.tick = q_end ? 8'h00 : st_q.tick + 8'h01;
            if (q_end) begin
                st_d.quarter = st_q.quarter + 2'h1;
            end
        end
        unique case (st_q.fsm)
            IDLE: begin
                st_d.scl_low = 1'b0;
                st_d.sda_low = 1'b0;
                if (cmd_valid) begin
                    st_d.fsm = START;
                    st_d.tick = 8'h00;
                    st_d.quarter = 2'h0;
                    st_d.shift = {cmd_addr, 1'b0};
                    st_d.rest = {cmd_reg, cmd_data};
                    st_d.byte_idx = 2'h0;
                    st_d.bit_idx = 3'h7;
                    st_d.nack = 1'b0;
                end
            end
            START: if (q_end) begin
                st_d.sda_low = 1'b1; // start: data falls while clock high
                if (st_q.quarter == 2'h3) begin
                    st_d.scl_low = 1'b1;
                    st_d.fsm = SEND;
                end
            end
            SEND, ACK: if (q_end) begin
                unique case (st_q.quarter)
                    2'h0: begin
                        st_d.scl_low = 1'b1;
                        st_d.sda_low = (st_q.fsm == SEND) ? !st_q.shift[7] : 1'b0;
                    end
                    2'h1: st_d.scl_low = 1'b0;
                    2'h2: st_d.scl_low = 1'b0;
                    2'h3: begin
                        st_d.scl_low = 1'b1;
                        if (st_q.fsm == SEND) begin
                            st_d.shift = {st_q.shift[6:0], 1'b0};
                            st_d.bit_idx = st_q.bit_idx - 3'h1;
                            if (st_q.bit_idx == 3'h0) begin
                                st_d.fsm = ACK;
                            end
                        end else if (sda_in || st_q.byte_idx == CTL_LAST_BYTE) begin
                            st_d.nack = sda_in;
                            st_d.fsm = STOP;
                        end else begin
                            st_d.shift = st_q.rest[15:8];
                            st_d.rest = {st_q.rest[7:0], 8'h00};
                            st_d.byte_idx = st_q.byte_idx + 2'h1;
                            st_d.bit_idx = 3'h7;
                            st_d.fsm = SEND;
                        end
                    end
                endcase
            end
            STOP: if (q_end) begin
                unique case (st_q.quarter)
                    2'h0: begin
                        st_d.scl_low = 1'b1;
                        st_d.sda_low = 1'b1;
                    end
                    2'h1: st_d.scl_low = 1'b1;
                    2'h2: st_d.scl_low = 1'b0;
                    2'h3: begin
                        st_d.sda_low = 1'b0; // stop: data rises while clock high
                        st_d.fsm = IDLE;
                    end
                endcase
            end
            default: st_d.fsm = IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // open drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n = !st_q.scl_low; // see RULE11
    assign sda_oe_n = !st_q.sda_low;
    assign busy = (st_q.fsm != IDLE);
    assign nack = st_q.nack;

    property p_ctl_idle_released;
        @(posedge core_clk) disable iff (!rst_n)
        (st_q.fsm == IDLE) ##1 (st_q.fsm == IDLE) |-> scl_oe_n && sda_oe_n;
    endproperty
    a_ctl_idle_released: assert property (p_ctl_idle_released) // see RULE11
        else $error("control link lines held while idle");

endmodule : ctl_link_master

// [voice_pcm_port.sv]
// Purpose: voice sample serial port with codec control link master
// Assumes: link pins are asynchronous; config and samples come from core_clk logic
// Notes: master bit clock comes from a phase accumulator, so edges jitter by one cycle
//
// Operation
// RULE1: short frame runs as master or slave
// RULE2: long frame only as master
// RULE3: every sample is sixteen linear bits
// RULE4: capture on falling, launch on rising edge
// RULE5: short frame: sync falling marks MSB
// RULE6: short frame rates up to 4096 kHz
// RULE7: long frame: sync rising marks MSB
// RULE8: long frame: 8 kHz half-duty sync
// RULE9: frame mode and rate are configurable
// RULE10: start-up: short frame, 2048 kHz, 8 kHz
// RULE11: control link: we always master the clock
// RULE12: clock and sync driven only as master
`timescale 1ns/1ns
module voice_pcm_port (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cfg_load,
    input wire logic cfg_long_frame,
    input wire logic cfg_master,
    input wire pcm_pkg::bclk_rate_t cfg_rate,
    input wire logic [15:0] tx_sample,
    output logic tx_take,
    output logic [15:0] rx_sample,
    output logic rx_valid,
    input wire logic bclk_i,
    output logic bclk_o,
    output logic bclk_oe_n,
    input wire logic sync_i,
    output logic sync_o,
    output logic sync_oe_n,
    input wire logic din,
    output logic dout,
    input wire logic ctl_cmd_valid,
    input wire logic [6:0] ctl_cmd_addr,
    input wire logic [7:0] ctl_cmd_reg,
    input wire logic [7:0] ctl_cmd_data,
    output logic ctl_busy,
    output logic ctl_nack,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);
    import pcm_pkg::*;

    typedef struct packed {
        logic long_mode;
        logic master;
        bclk_rate_t rate;
        logic [31:0] phase;
        logic clk_prev;
        logic sync_at_fall;
        logic [8:0] bit_cnt;
        logic [15:0] tx_shift;
        logic [15:0] rx_shift;
        logic [15:0] rx_sample;
        logic rx_valid;
        logic tx_take;
        logic dout;
        logic sync_out;
    } port_state_t;

    port_state_t st_q;
    port_state_t st_d;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    logic rst_meta_q;
    logic rst_n;
    logic bclk_s;
    logic sync_s;
    logic din_s;
    logic sda_s;

    // release the reset through two flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    bit_sync #(.WIDTH(4)) u_pin_sync (
        .core_clk(core_clk),
        .reset_n(rst_n),
        .async_in({bclk_i, sync_i, din, sda_i}),
        .sync_out({bclk_s, sync_s, din_s, sda_s})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // rate decode

    logic [31:0] step;
    logic [8:0] frame_bits;

    // phase step and slots per frame for each rate
    always_comb begin
        unique case (st_q.rate)
            RATE_256: begin
                step = STEP_256;
                frame_bits = FRAME_256;
            end
            RATE_512: begin
                step = STEP_512;
                frame_bits = FRAME_512;
            end
            RATE_1024: begin
                step = STEP_1024;
                frame_bits = FRAME_1024;
            end
            RATE_2048: begin
                step = STEP_2048;
                frame_bits = FRAME_2048;
            end
            RATE_4096: begin
                step = STEP_4096; // 16 kHz sync at 256 slots, see RULE6
                frame_bits = FRAME_4096;
            end
            default: begin
                step = STEP_2048;
                frame_bits = FRAME_2048;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame engine

    logic clk_now;
    logic rise_ev;
    logic fall_ev;
    logic frame_start;
    logic [8:0] next_cnt;

    always_comb begin
        st_d = st_q;
        st_d.rx_valid = 1'b0;
        st_d.tx_take = 1'b0;
        // master runs the accumulator, slave follows the pin
        if (st_q.master) begin
            st_d.phase = st_q.phase + step;
        end else begin
            st_d.phase = '0;
        end
        clk_now = st_q.master ? st_q.phase[31] : bclk_s; // see RULE12
        st_d.clk_prev = clk_now;
        rise_ev = clk_now && !st_q.clk_prev;
        fall_ev = !clk_now && st_q.clk_prev;
        // master wraps on its own count, slave waits for sync seen high
        if (st_q.master) begin
            frame_start = (st_q.bit_cnt >= frame_bits - 9'h001); // see RULE1
        end else begin
            frame_start = st_q.sync_at_fall; // see RULE1
        end
        if (frame_start) begin
            next_cnt = 9'h000;
        end else if (st_q.bit_cnt == BIT_IDLE) begin
            next_cnt = BIT_IDLE;
        end else begin
            next_cnt = st_q.bit_cnt + 9'h001;
        end
        // launch side
        if (rise_ev) begin
            st_d.bit_cnt = next_cnt;
            if (frame_start) begin
                st_d.tx_shift = tx_sample;
                st_d.dout = tx_sample[15]; // see RULE4
                st_d.tx_take = 1'b1;
            end else if (next_cnt <= LAST_DATA_BIT) begin
                st_d.dout = st_q.tx_shift[14]; // see RULE3
                st_d.tx_shift = {st_q.tx_shift[14:0], 1'b0};
            end else begin
                st_d.dout = 1'b0;
            end
            if (st_q.long_mode) begin
                st_d.sync_out = (next_cnt < (frame_bits >> 1)); // see RULE7 RULE8
            end else begin
                st_d.sync_out = (next_cnt == frame_bits - 9'h001); // see RULE5
            end
        end
        // capture side
        if (fall_ev) begin
            st_d.sync_at_fall = sync_s && !st_q.long_mode;
            if (st_q.bit_cnt <= LAST_DATA_BIT) begin
                st_d.rx_shift = {st_q.rx_shift[14:0], din_s}; // see RULE4
                if (st_q.bit_cnt == LAST_DATA_BIT) begin
                    st_d.rx_sample = {st_q.rx_shift[14:0], din_s}; // see RULE3
                    st_d.rx_valid = 1'b1;
                end
            end
        end
        // new configuration restarts the frame
        if (cfg_load) begin
            st_d.long_mode = cfg_long_frame; // see RULE9
            st_d.master = cfg_master || cfg_long_frame; // see RULE2
            st_d.rate = (cfg_long_frame && cfg_rate == RATE_4096) ? RATE_2048 : cfg_rate;
            st_d.bit_cnt = BIT_IDLE;
            st_d.sync_at_fall = 1'b0;
            st_d.sync_out = 1'b0;
            st_d.dout = 1'b0;
        end
    end

    // start-up defaults, see RULE10
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.long_mode <= DEFAULT_LONG;
            st_q.master <= DEFAULT_MASTER;
            st_q.rate <= DEFAULT_RATE;
            st_q.bit_cnt <= BIT_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pins and user side

    assign bclk_o = st_q.phase[31];
    assign sync_o = st_q.sync_out;
    assign bclk_oe_n = !st_q.master; // see RULE12
    assign sync_oe_n = !st_q.master;
    assign dout = st_q.dout;
    assign rx_sample = st_q.rx_sample;
    assign rx_valid = st_q.rx_valid;
    assign tx_take = st_q.tx_take;

    ctl_link_master u_ctl (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cmd_valid(ctl_cmd_valid),
        .cmd_addr(ctl_cmd_addr),
        .cmd_reg(ctl_cmd_reg),
        .cmd_data(ctl_cmd_data),
        .busy(ctl_busy),
        .nack(ctl_nack),
        .sda_in(sda_s),
        .scl_o(scl_o),
        .scl_oe_n(scl_oe_n),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_release;
        !rst_n ##1 rst_n;
    endsequence

    property p_boot_default;
        @(posedge core_clk) s_release |-> !st_q.long_mode && st_q.rate == RATE_2048;
    endproperty
    a_boot_default: assert property (p_boot_default) // see RULE10
        else $error("start-up configuration wrong");

    property p_long_master;
        @(posedge core_clk) disable iff (!rst_n)
        st_q.long_mode |-> st_q.master && !bclk_oe_n;
    endproperty
    a_long_master: assert property (p_long_master) // see RULE2
        else $error("long frame without master drive");

    property p_slave_released;
        @(posedge core_clk) disable iff (!rst_n)
        !st_q.master |-> bclk_oe_n && sync_oe_n;
    endproperty
    a_slave_released: assert property (p_slave_released) // see RULE1 RULE12
        else $error("slave drives clock or sync");

    property p_rx_on_fall;
        @(posedge core_clk) disable iff (!rst_n)
        rx_valid |-> $past(fall_ev) && $past(st_q.bit_cnt) == LAST_DATA_BIT;
    endproperty
    a_rx_on_fall: assert property (p_rx_on_fall) // see RULE3 RULE4
        else $error("sample completed off the falling edge");

    property p_dout_on_rise;
        @(posedge core_clk) disable iff (!rst_n)
        $changed(dout) && !$past(cfg_load) |-> $past(rise_ev);
    endproperty
    a_dout_on_rise: assert property (p_dout_on_rise) // see RULE4
        else $error("data launched off the rising edge");

    property p_short_msb;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(sync_o) && st_q.master && !st_q.long_mode && !$past(cfg_load)
            |-> st_q.bit_cnt == 9'h000 && tx_take;
    endproperty
    a_short_msb: assert property (p_short_msb) // see RULE5
        else $error("short sync fall not at MSB");

    property p_long_msb;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(sync_o) && st_q.long_mode |-> st_q.bit_cnt == 9'h000 && tx_take;
    endproperty
    a_long_msb: assert property (p_long_msb) // see RULE7
        else $error("long sync rise not at MSB");

    sequence s_long_half;
        st_q.long_mode && rise_ev && next_cnt == (frame_bits >> 1);
    endsequence

    property p_long_duty;
        @(posedge core_clk) disable iff (!rst_n || cfg_load)
        s_long_half |=> !sync_o;
    endproperty
    a_long_duty: assert property (p_long_duty) // see RULE8
        else $error("long sync not half duty");

    property p_cfg_apply;
        @(posedge core_clk) disable iff (!rst_n)
        cfg_load && !cfg_long_frame |=> st_q.rate == $past(cfg_rate) && st_q.master == $past(cfg_master);
    endproperty
    a_cfg_apply: assert property (p_cfg_apply) // see RULE9
        else $error("configuration not applied");

    property p_frame_len;
        @(posedge core_clk) disable iff (!rst_n || cfg_load)
        st_q.master && rise_ev && frame_start |-> st_q.bit_cnt == frame_bits - 9'h001 || st_q.bit_cnt == BIT_IDLE;
    endproperty
    a_frame_len: assert property (p_frame_len) // see RULE6
        else $error("frame length wrong");

endmodule : voice_pcm_port

// [codec_model.sv]
// Purpose: behavioural audio codec on the far side of the voice sample port
// Assumes: pins arrive as wire levels
// Notes: drives clock and sync only inside run_frames
`timescale 1ns/1ns
module codec_model (
    input wire logic bclk,
    input wire logic sync,
    input wire logic dout,
    input wire logic long_mode,
    input wire logic [15:0] tx_word,
    output logic din,
    output logic m_bclk,
    output logic m_sync,
    output logic [15:0] rx_word,
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    output logic sda_pull,
    output logic [23:0] ctl_bytes,
    output int ctl_n
);
    int ti = 40, ri = 16, bn = 0;
    logic ps = 1'b0;
    logic [15:0] sh;
    logic [7:0] cs;

    // quiet pins until something happens
    initial begin
        din = 1'b0;
        m_bclk = 1'b0;
        m_sync = 1'b0;
        sda_pull = 1'b0;
        ctl_n = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // outside slots 0..15 the line toggles
    task automatic put(input int i);
        din = (i < 16) ? tx_word[15-i] : ~din;
    endtask : put

    // launch on rising edge; short frame restarts on sync high
    always @(posedge bclk) begin
        if (!long_mode && sync) ti = 0;
        else if (ti < 40) ti++;
        put(ti);
    end

    // long frame: sync rising carries the msb
    always @(posedge sync) begin
        if (long_mode) begin
            ti = 0;
            put(0);
        end
    end

    // capture on falling edge, frame start from the sync edge
    always @(negedge bclk) begin
        if (long_mode ? (sync && !ps) : (!sync && ps)) ri = 0;
        ps = sync;
        if (ri < 16) begin
            sh = {sh[14:0], dout};
            ri++;
            if (ri == 16) rx_word = sh;
        end
    end

    // act as clock master for n frames of 32 slots, 80 ns bit period
    task automatic run_frames(input int n);
        #3;
        for (int k = 0; k < n * 32 + 1; k++) begin
            m_bclk = 1'b1;
            #5 m_sync = ((k + 31) % 32 == 31);
            #35 m_bclk = 1'b0;
            #40;
        end
    endtask : run_frames

    ////////////////////////////////////////////////////////////////////////
    // start condition clears the counts
    always @(negedge sda) begin
        #1;
        if (scl) begin
            bn = 0;
            ctl_n = 0;
        end
    end

    // bits taken while the clock is high, msb first
    always @(posedge scl) begin
        if (bn < 8) begin
            cs = {cs[6:0], sda};
            bn++;
        end else bn = 0;
    end

    // target only: acks the ninth slot
    always @(negedge scl) begin
        if (bn == 8) begin
            ctl_bytes = {ctl_bytes[15:0], cs};
            ctl_n++;
        end
        sda_pull = (bn == 8) && ack_en;
    end
endmodule : codec_model

// [tb.sv]
// Purpose: self-checking bench of the voice sample port
// Assumes: codec_model on the link
// Notes: bit clock spans allow two cycles of accumulator jitter
`timescale 1ns/1ns
module tb;
    import pcm_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cfg_load = 1'b0, cfg_long_frame = 1'b0, cfg_master = 1'b1;
    bclk_rate_t cfg_rate = RATE_2048;
    logic [15:0] tx_sample = 16'ha5c3, c_tx = 16'h3c5a;
    logic c_long = 1'b0, ack_en = 1'b1, ctl_cmd_valid = 1'b0;
    logic [6:0] ctl_cmd_addr = 7'h00;
    logic [7:0] ctl_cmd_reg = 8'h00, ctl_cmd_data = 8'h00;
    logic tx_take, rx_valid, bclk_o, bclk_oe_n, sync_o, sync_oe_n, dout, din;
    logic ctl_busy, ctl_nack, scl_o, scl_oe_n, sda_o, sda_oe_n, sda_pull, m_bclk, m_sync;
    logic [15:0] rx_sample, c_rx;
    logic [23:0] c_bytes;
    logic [2:0] m_q;
    int c_n;
    int bad_count = 0, checks_done = 0;
    // pins and edges: bit 2 bclk rise, 1 sync fall, 0 sync rise
    wire bclk_w = bclk_oe_n ? m_bclk : bclk_o;
    wire sync_w = sync_oe_n ? m_sync : sync_o;
    wire scl_w = scl_oe_n | scl_o;
    wire sda_w = (sda_oe_n | sda_o) & ~sda_pull;
    wire [2:0] m = {bclk_o, ~sync_o, sync_o};
    wire [2:0] rs = m & ~m_q;

    // clock and edge history
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) m_q <= m;

    voice_pcm_port i_voice_pcm_port (.core_clk, .reset_n, .cfg_load, .cfg_long_frame,
        .cfg_master, .cfg_rate, .tx_sample, .tx_take, .rx_sample, .rx_valid,
        .bclk_i(bclk_w), .bclk_o, .bclk_oe_n, .sync_i(sync_w), .sync_o, .sync_oe_n, .din,
        .dout, .ctl_cmd_valid, .ctl_cmd_addr, .ctl_cmd_reg, .ctl_cmd_data, .ctl_busy,
        .ctl_nack, .scl_i(scl_w), .scl_o, .scl_oe_n, .sda_i(sda_w), .sda_o, .sda_oe_n);

    codec_model i_codec_model (.bclk(bclk_w), .sync(sync_w), .dout(dout),
        .long_mode(c_long), .tx_word(c_tx), .din(din), .m_bclk(m_bclk), .m_sync(m_sync),
        .rx_word(c_rx), .scl(scl_w), .sda(sda_w), .ack_en(ack_en), .sda_pull(sda_pull),
        .ctl_bytes(c_bytes), .ctl_n(c_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic cfg(input logic l, ms, input bclk_rate_t r);
        @(posedge core_clk);
        cfg_long_frame <= l;
        cfg_master <= ms;
        cfg_rate <= r;
        cfg_load <= 1'b1;
        @(posedge core_clk);
        cfg_load <= 1'b0;
        @(posedge core_clk);
    endtask : cfg

    // cycles from an edge a to the n-th later edge b
    task automatic span(input string nm, input int a, b, n, e);
        int c = 0;
        @(posedge core_clk);
        while (!rs[a]) @(posedge core_clk);
        repeat (n) begin
            do begin
                @(posedge core_clk);
                c++;
            end while (!rs[b]);
        end
        check(nm, 32'((c > e - 3 && c < e + 3) ? e : c), 32'(e));
    endtask : span

    task automatic ctl_write(input logic [6:0] a, input logic [7:0] r, d, input logic nk);
        @(posedge core_clk);
        ctl_cmd_addr <= a;
        ctl_cmd_reg <= r;
        ctl_cmd_data <= d;
        ctl_cmd_valid <= 1'b1;
        @(posedge core_clk);
        ctl_cmd_valid <= 1'b0;
        @(posedge core_clk);
        check("ctl_busy", ctl_busy, 1);
        while (ctl_busy) @(posedge core_clk);
        @(posedge core_clk);
        check("ctl_nack", ctl_nack, nk);
        check("ctl_count", c_n, nk ? 1 : 3);
        if (!nk) check("ctl_bytes", c_bytes, {a, 1'b0, r, d});
    endtask : ctl_write

    ////////////////////////////////////////////////////////////////////////
    task automatic t_default;
        check("bclk_oe_n", bclk_oe_n, 0);
        check("sync_oe_n", sync_oe_n, 0);
        fork
            ctl_write(7'h1a, 8'h05, 8'hc7, 1'b0);
            begin
                span("bclk_2048", 2, 2, 8, 391);
                span("sync_8k", 1, 1, 1, 12500);
                check("codec_rx", c_rx, 16'ha5c3);
                check("rx_sample", rx_sample, 16'h3c5a);
            end
        join
    endtask : t_default

    task automatic t_rates;
        int khz[5] = '{256, 512, 1024, 2048, 4096};
        for (int k = 0; k < 5; k++) begin
            cfg(1'b0, 1'b1, bclk_rate_t'(k));
            span("bclk_rate", 2, 2, 8, 800000 / khz[k]);
        end
        span("sync_16k", 1, 1, 1, 6250);
    endtask : t_rates

    task automatic t_long;
        tx_sample <= 16'h8e31;
        c_tx <= 16'h70c6;
        c_long <= 1'b1;
        cfg(1'b1, 1'b0, RATE_2048);
        check("long_oe_n", {bclk_oe_n, sync_oe_n}, 0);
        span("sync_half", 0, 1, 1, 6250);
        check("codec_rx_long", c_rx, 16'h8e31);
        check("rx_long", rx_sample, 16'h70c6);
    endtask : t_long

    task automatic t_slave;
        tx_sample <= 16'h5b2d;
        c_tx <= 16'hd4e9;
        c_long <= 1'b0;
        cfg(1'b0, 1'b0, RATE_2048);
        check("slave_oe_n", {bclk_oe_n, sync_oe_n}, 3);
        i_codec_model.run_frames(3);
        repeat (10) @(posedge core_clk);
        check("codec_rx_slave", c_rx, 16'h5b2d);
        check("rx_slave", rx_sample, 16'hd4e9);
    endtask : t_slave

    task automatic t_nack;
        ack_en <= 1'b0;
        ctl_write(7'h33, 8'h10, 8'h20, 1'b1);
    endtask : t_nack

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_default;
        t_rates;
        t_long;
        t_slave;
        t_nack;
        print_verdict;
    end

    // watchdog past the expected run of about 66000 cycles
    initial begin
        repeat (95000) @(posedge core_clk);
        bad_count++;
        print_verdict;
    end
endmodule : tb
